// ==== rtl/capacitive_key_scan_expander.sv ====
module capacitive_key_scan_expander #(
    parameter int SCAN_LINES  = key_scan_pkg::SCAN_LINES_FULL,
    parameter int TIMEOUT_CYC = key_scan_pkg::ALE_TIMEOUT_CYC
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  ale_in,
    input  wire logic                  expansion_strobe_n_in,
    input  wire logic [3:0]            nibble_port_in,
    input  wire logic [7:0]            sense_in,
    output logic      [3:0]            nibble_port_out,
    output logic                       nibble_port_oe_out,
    output logic      [SCAN_LINES-1:0] scan_drive_out,
    output logic                       antiscan_out,
    output logic                       zeroing_out,
    output logic      [7:0]            sense_latched_out
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ZERO = 2'b01,
        ST_SCAN = 2'b10
    } wr_state_e;

    localparam int CTL_W  = 2;
    localparam int DATA_W = key_scan_pkg::NIBBLE_W + key_scan_pkg::SENSE_W;

    localparam logic [CTL_W-1:0] CTL_RST =
        {key_scan_pkg::STRB_RST, key_scan_pkg::ALE_RST};
    localparam logic [DATA_W-1:0] DATA_RST =
        {key_scan_pkg::SENSE_RST, key_scan_pkg::NIB_RST};
    localparam logic [key_scan_pkg::TIMER_W-1:0] TIMEOUT_LIM =
        key_scan_pkg::TIMER_W'(TIMEOUT_CYC);

    // address nibble fields, decoded at the fall and again later
    function automatic logic [1:0] port_field(input logic [3:0] nib);
        return nib[key_scan_pkg::PORT_LSB +: 2];
    endfunction : port_field

    function automatic logic [1:0] op_field(input logic [3:0] nib);
        return nib[key_scan_pkg::OP_LSB +: 2];
    endfunction : op_field

    // ports six and seven belong to other expanders
    function automatic logic port_hit(input logic [1:0] port);
        return (port == key_scan_pkg::PORT_FOUR) ||
               (port == key_scan_pkg::PORT_FIVE);
    endfunction : port_hit

    // synchronised pins
    logic [CTL_W-1:0]  ctl_lvl;
    logic [CTL_W-1:0]  ctl_rise;
    logic [CTL_W-1:0]  ctl_fall;
    logic [DATA_W-1:0] data_lvl;

    logic       ale_rise;
    logic       ale_fall;
    logic       strb_rise;
    logic       strb_fall;
    logic [3:0] nib_s;
    logic [7:0] sense_s;

    edge_sync #(
        .WIDTH   (CTL_W),
        .RST_VAL (CTL_RST)
    ) u_ctl_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  ({expansion_strobe_n_in, ale_in}),
        .level_out (ctl_lvl),
        .rise_out  (ctl_rise),
        .fall_out  (ctl_fall)
    );

    // data takes the same two stages, so it lines up with the edges
    edge_sync #(
        .WIDTH   (DATA_W),
        .RST_VAL (DATA_RST)
    ) u_data_sync (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .async_in  ({sense_in, nibble_port_in}),
        .level_out (data_lvl),
        .rise_out  (),
        .fall_out  ()
    );

    always_comb begin
        ale_rise  = ctl_rise[0];
        ale_fall  = ctl_fall[0];
        strb_rise = ctl_rise[1];
        strb_fall = ctl_fall[1];
        nib_s     = data_lvl[3:0];
        sense_s   = data_lvl[11:4];
    end

    // address and operation latch
    logic [1:0] port_r;
    logic [1:0] port_nxt;
    logic [1:0] op_r;
    logic [1:0] op_nxt;
    logic [1:0] new_port;
    logic       new_hit;

    always_comb begin
        port_nxt = port_r;
        op_nxt   = op_r;
        new_port = port_field(nib_s);
        new_hit  = port_hit(new_port);
        if (strb_fall) begin
            port_nxt = new_port;
            op_nxt   = op_field(nib_s);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_r <= key_scan_pkg::ADDR_RST;
            op_r   <= key_scan_pkg::OP_READ;
        end else begin
            port_r <= port_nxt;
            op_r   <= op_nxt;
        end
    end

    logic write_start;
    logic read_start;

    // foreign ports and the OR/AND operations never start anything
    always_comb begin
        write_start = strb_fall && new_hit &&
            (op_field(nib_s) == key_scan_pkg::OP_WRITE);
        read_start  = strb_fall && new_hit &&
            (op_field(nib_s) == key_scan_pkg::OP_READ);
    end

    // write sequence: zero, then scan for one latch pulse
    wr_state_e                         state_r;
    wr_state_e                         state_nxt;
    logic [3:0]                        code_r;
    logic [3:0]                        code_nxt;
    logic                              code_ok_r;
    logic                              code_ok_nxt;
    logic                              zero_r;
    logic                              zero_nxt;
    logic [SCAN_LINES-1:0]             scan_r;
    logic [SCAN_LINES-1:0]             scan_nxt;
    logic                              anti_r;
    logic                              anti_nxt;
    logic [key_scan_pkg::TIMER_W-1:0]  timer_r;
    logic [key_scan_pkg::TIMER_W-1:0]  timer_nxt;
    logic [SCAN_LINES-1:0]             decoded;
    logic                              timed_out;

    // lines stay dark until a code has been taken
    scan_decoder #(
        .LINES (SCAN_LINES)
    ) u_decode (
        .enable_in (code_ok_r),
        .code_in   (code_r),
        .line_out  (decoded)
    );

    always_comb begin
        state_nxt   = state_r;
        code_nxt    = code_r;
        code_ok_nxt = code_ok_r;
        zero_nxt    = zero_r;
        scan_nxt    = scan_r;
        // a lost latch strobe must not leave a line driven forever
        timed_out   = (state_r != ST_IDLE) && (timer_r >= TIMEOUT_LIM);
        timer_nxt   = (ale_rise || ale_fall || state_r == ST_IDLE) ?
                      '0 : timer_r + 1'b1;
        if (write_start) begin
            state_nxt   = ST_ZERO;
            zero_nxt    = 1'b1;
            code_ok_nxt = 1'b0;
            scan_nxt    = '0;
            timer_nxt   = '0;
        end else if (timed_out) begin
            state_nxt   = ST_IDLE;
            zero_nxt    = 1'b0;
            scan_nxt    = '0;
            code_ok_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_ZERO: begin
                    // a foreign access in between must not load a code
                    if (strb_rise && !code_ok_r && port_hit(port_r) &&
                        op_r == key_scan_pkg::OP_WRITE) begin
                        code_nxt    = nib_s;
                        code_ok_nxt = 1'b1;
                    end else if (ale_rise && code_ok_r) begin
                        state_nxt = ST_SCAN;
                        zero_nxt  = 1'b0;
                        scan_nxt  = decoded;
                    end
                end
                ST_SCAN: begin
                    if (ale_fall) begin
                        state_nxt   = ST_IDLE;
                        scan_nxt    = '0;
                        code_ok_nxt = 1'b0;
                    end
                end
                default: begin
                    zero_nxt = 1'b0;
                    scan_nxt = '0;
                end
            endcase
        end
        anti_nxt = ~|scan_nxt;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r   <= ST_IDLE;
            code_r    <= key_scan_pkg::CODE_RST;
            code_ok_r <= 1'b0;
            zero_r    <= 1'b0;
            scan_r    <= '0;
            anti_r    <= 1'b1;
            timer_r   <= '0;
        end else begin
            state_r   <= state_nxt;
            code_r    <= code_nxt;
            code_ok_r <= code_ok_nxt;
            zero_r    <= zero_nxt;
            scan_r    <= scan_nxt;
            anti_r    <= anti_nxt;
            timer_r   <= timer_nxt;
        end
    end

    // sense capture: pulses are short, so collect them over the scan
    logic [7:0] sense_acc_r;
    logic [7:0] sense_acc_nxt;
    logic [7:0] sense_hold_r;
    logic [7:0] sense_hold_nxt;

    always_comb begin
        sense_acc_nxt  = sense_acc_r;
        sense_hold_nxt = sense_hold_r;
        if (state_nxt == ST_SCAN && state_r != ST_SCAN) begin
            sense_acc_nxt = '0;
        end else if (state_r == ST_SCAN) begin
            sense_acc_nxt = sense_acc_r | sense_s;
            if (state_nxt != ST_SCAN) begin
                sense_hold_nxt = sense_acc_r | sense_s;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sense_acc_r  <= key_scan_pkg::SENSE_RST;
            sense_hold_r <= key_scan_pkg::SENSE_RST;
        end else begin
            sense_acc_r  <= sense_acc_nxt;
            sense_hold_r <= sense_hold_nxt;
        end
    end

    // read path: both halves come from one held byte, so a pair of
    // reads sees a consistent key snapshot unless a scan ends between them
    logic       oe_r;
    logic       oe_nxt;
    logic [3:0] nib_out_r;
    logic [3:0] nib_out_nxt;

    always_comb begin
        oe_nxt      = oe_r;
        nib_out_nxt = nib_out_r;
        if (read_start) begin
            oe_nxt = 1'b1;
            if (new_port == key_scan_pkg::PORT_FIVE) begin
                nib_out_nxt = sense_hold_r[7:4];
            end else begin
                nib_out_nxt = sense_hold_r[3:0];
            end
        end else if (strb_rise || strb_fall) begin
            // released only after the controller sampled at its rise
            oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            oe_r      <= 1'b0;
            nib_out_r <= key_scan_pkg::NIB_RST;
        end else begin
            oe_r      <= oe_nxt;
            nib_out_r <= nib_out_nxt;
        end
    end

    // every output is a plain register, no gating after the flops
    always_comb begin
        nibble_port_out    = nib_out_r;
        nibble_port_oe_out = oe_r;
        scan_drive_out     = scan_r;
        antiscan_out       = anti_r;
        zeroing_out        = zero_r;
        sense_latched_out  = sense_hold_r;
    end

endmodule : capacitive_key_scan_expander

// ==== pkg/key_scan_pkg.sv ====
// Behaviour
// - strobe fall captures address and operation nibble
// - write: strobe rise captures scan line code
// - read port five drives sense bits seven-four
// - read port four drives sense bits three-zero
// - two reads alternate halves of latched byte
// - write cycle starts zeroing phase at strobe
// - next latch rise ends zeroing, activates scan
// - following latch fall deactivates the scan line
// - scan code decodes to exactly one line, none for codes eleven-fifteen on reduced variant
// - antiscan active exactly when no line driven
// - reduced variant has only eleven scan lines
// - read mode entered at strobe fall
// - only ports four and five answered
// - latch strobe is the only time base; a write also ends after TIMEOUT_CYC clk_in cycles with no latch edge
// - eight sense inputs catch key pulses
// - address bits: port low, operation high
package key_scan_pkg;

    localparam int NIBBLE_W           = 4;
    localparam int SENSE_W            = 8;
    localparam int SCAN_LINES_FULL    = 16;
    localparam int SCAN_LINES_REDUCED = 11;

    // address nibble layout
    localparam int PORT_LSB = 0;
    localparam int OP_LSB   = 2;

    localparam logic [1:0] PORT_FOUR = 2'h0;
    localparam logic [1:0] PORT_FIVE = 2'h1;

    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_OR    = 2'h2;
    localparam logic [1:0] OP_AND   = 2'h3;

    // reset values
    localparam logic [1:0]  ADDR_RST  = 2'h3;
    localparam logic [3:0]  CODE_RST  = 4'h0;
    localparam logic [3:0]  NIB_RST   = 4'h0;
    localparam logic [7:0]  SENSE_RST = 8'h00;
    localparam logic        ALE_RST   = 1'b0;
    localparam logic        STRB_RST  = 1'b1;

    // timing
    localparam int CLK_PERIOD_NS     = 4;
    localparam int ALE_MAX_PERIOD_NS = 15015;
    localparam int ALE_TIMEOUT_CYC   = ALE_MAX_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TIMER_W           = 13;

endpackage : key_scan_pkg

// ==== rtl/edge_sync.sv ====
module edge_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out,
    output logic      [WIDTH-1:0] fall_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] prev_r;

    // meta_r feeds sync_r only
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
            prev_r <= RST_VAL;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    always_comb begin
        level_out = sync_r;
        rise_out  = sync_r & ~prev_r;
        fall_out  = ~sync_r & prev_r;
    end

endmodule : edge_sync

// ==== rtl/scan_decoder.sv ====
module scan_decoder #(
    parameter int LINES = 16
) (
    input  wire logic             enable_in,
    input  wire logic [3:0]       code_in,
    output logic      [LINES-1:0] line_out
);

    function automatic logic [LINES-1:0] one_hot(input logic [3:0] code);
        logic [LINES-1:0] v;
        v = '0;
        for (int i = 0; i < LINES; i++) begin
            if (code == 4'(i)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction : one_hot

    // codes past the last line select nothing on the reduced part
    always_comb begin
        line_out = enable_in ? one_hot(code_in) : '0;
    end

endmodule : scan_decoder

// ==== sim/key_scan_sva.sv ====
module key_scan_sva #(
    parameter int SCAN_LINES = 16
) (
    input wire logic                  clk_in,
    input wire logic                  rst_n_in,
    input wire logic                  ale_in,
    input wire logic                  expansion_strobe_n_in,
    input wire logic [3:0]            nibble_port_in,
    input wire logic [3:0]            nibble_port_out,
    input wire logic                  nibble_port_oe_out,
    input wire logic [SCAN_LINES-1:0] scan_drive_out,
    input wire logic                  antiscan_out,
    input wire logic                  zeroing_out,
    input wire logic [7:0]            sense_latched_out
);
    logic strb_r;
    logic strb_nxt;
    logic port_hi_r;
    logic port_hi_nxt;

    // remember which port the running access addressed
    always_comb begin
        strb_nxt    = expansion_strobe_n_in;
        port_hi_nxt = port_hi_r;
        if (strb_r && !expansion_strobe_n_in) begin
            port_hi_nxt = nibble_port_in[0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strb_r    <= 1'b1;
            port_hi_r <= 1'b0;
        end else begin
            strb_r    <= strb_nxt;
            port_hi_r <= port_hi_nxt;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_wr_fall;
        $fell(expansion_strobe_n_in) && nibble_port_in[3:1] == 3'h2;
    endsequence
    sequence s_rd_fall;
        $fell(expansion_strobe_n_in) && nibble_port_in[3:1] == 3'h0;
    endsequence

    a_zero_start: assert property (
        s_wr_fall |-> ##[2:4] zeroing_out)
        else $error("zeroing did not start after write strobe");
    a_read_enter: assert property (
        s_rd_fall |-> ##[2:4] nibble_port_oe_out)
        else $error("port not driven after read strobe");
    a_port_refuse: assert property (
        $fell(expansion_strobe_n_in) && (nibble_port_in[1] || nibble_port_in[3])
        |-> (!nibble_port_oe_out && !zeroing_out) [*6])
        else $error("foreign port or operation was answered");
    a_read_data: assert property (
        nibble_port_oe_out |-> nibble_port_out == (port_hi_r ?
        sense_latched_out[7:4] : sense_latched_out[3:0]))
        else $error("wrong sense nibble on the port");
    a_read_release: assert property (
        $rose(expansion_strobe_n_in) |-> ##[2:5] !nibble_port_oe_out)
        else $error("port still driven after strobe rise");
    a_scan_onehot: assert property (
        $onehot0(scan_drive_out))
        else $error("more than one scan line active");
    a_antiscan_inv: assert property (
        antiscan_out == (scan_drive_out == '0))
        else $error("antiscan does not mirror scan lines");
    a_scan_on: assert property (
        $rose(|scan_drive_out) |-> $past(ale_in, 2) && $past(zeroing_out)
        && !zeroing_out)
        else $error("scan started off the zeroing ale rise");
    a_scan_off: assert property (
        $fell(|scan_drive_out) |-> !$past(ale_in, 2))
        else $error("scan ended off an ale fall");
    a_latch_quiet: assert property (
        $changed(sense_latched_out) |-> !(|scan_drive_out) && !zeroing_out)
        else $error("sense byte changed during scan");
endmodule : key_scan_sva

bind capacitive_key_scan_expander key_scan_sva #(
    .SCAN_LINES(SCAN_LINES)
) u_key_scan_sva (
    .clk_in                (clk_in),
    .rst_n_in              (rst_n_in),
    .ale_in                (ale_in),
    .expansion_strobe_n_in (expansion_strobe_n_in),
    .nibble_port_in        (nibble_port_in),
    .nibble_port_out       (nibble_port_out),
    .nibble_port_oe_out    (nibble_port_oe_out),
    .scan_drive_out        (scan_drive_out),
    .antiscan_out          (antiscan_out),
    .zeroing_out           (zeroing_out),
    .sense_latched_out     (sense_latched_out)
);

// ==== sim/host_ctrl_model.sv ====
module host_ctrl_model (
    input  wire logic       clk_in,
    input  wire logic [3:0] nib_wire_in,
    output logic            ale_out,
    output logic            strobe_n_out,
    output logic      [3:0] nib_out,
    output logic            nib_oe_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // free running time base, low when reset lifts
    initial begin
        ale_out = 1'b0;
        #71.3;
        forever #40 ale_out = ~ale_out;
    end

    initial begin
        strobe_n_out = 1'b1;
        nib_out      = 4'h0;
        nib_oe_out   = 1'b0;
    end

    // writes start at ale rise, reads at ale fall
    // strobe rises ahead of the next ale rise on writes, just after it on reads
    task automatic access(input logic [3:0] addr, input logic [3:0] wdata,
                          output logic [3:0] rdata);
        if (addr[3:2] == 2'h0) @(negedge ale_out);
        else @(posedge ale_out);
        @(negedge clk_in);
        strobe_n_out = 1'b0;
        nib_out      = addr;
        nib_oe_out   = 1'b1;
        repeat (4) @(negedge clk_in);
        nib_oe_out = (addr[3:2] != 2'h0);
        nib_out    = wdata;
        repeat (8) @(negedge clk_in);
        rdata        = nib_wire_in;
        strobe_n_out = 1'b1;
        repeat (4) @(negedge clk_in);
        nib_oe_out = 1'b0;
    endtask : access
endmodule : host_ctrl_model

// ==== sim/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_in;
    logic        rst_n_in;
    logic        ale;
    logic        strobe_n;
    logic [3:0]  ctrl_nib;
    logic        ctrl_oe;
    logic [3:0]  idle_nib = 4'h0;
    logic [3:0]  nib_wire;
    logic [7:0]  sense;
    logic [3:0]  dev_nib;
    logic        dev_oe;
    logic [15:0] scan;
    logic        antiscan;
    logic        zeroing;
    logic [7:0]  latched;
    logic        seen = 1'b0;
    int          err_total = 0;
    int          check_count = 0;

    // a released port wanders so stale values never pass
    assign nib_wire = dev_oe ? dev_nib : (ctrl_oe ? ctrl_nib : idle_nib);
    always @(posedge clk_in) idle_nib <= ~idle_nib;
    always @(posedge clk_in) if (dev_oe || zeroing) seen <= 1'b1;

    capacitive_key_scan_expander #(
        .SCAN_LINES  (16),
        .TIMEOUT_CYC (200)
    ) u_capacitive_key_scan_expander (
        .clk_in                (clk_in),
        .rst_n_in              (rst_n_in),
        .ale_in                (ale),
        .expansion_strobe_n_in (strobe_n),
        .nibble_port_in        (nib_wire),
        .sense_in              (sense),
        .nibble_port_out       (dev_nib),
        .nibble_port_oe_out    (dev_oe),
        .scan_drive_out        (scan),
        .antiscan_out          (antiscan),
        .zeroing_out           (zeroing),
        .sense_latched_out     (latched)
    );

    host_ctrl_model u_host_ctrl_model (
        .clk_in       (clk_in),
        .nib_wire_in  (nib_wire),
        .ale_out      (ale),
        .strobe_n_out (strobe_n),
        .nib_out      (ctrl_nib),
        .nib_oe_out   (ctrl_oe)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wait_scan(input logic want_on);
        int n = 0;
        while ((|scan) !== want_on && n < 60) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 60) begin
            err_total++;
            end_sim();
        end
    endtask : wait_scan

    task automatic t_reset();
        repeat (4) @(negedge clk_in);
        check(scan, 16'h0000);
        check({antiscan, zeroing, dev_oe}, 3'h4);
        check(latched, 8'h00);
    endtask : t_reset

    // every code, writes through port four and five alike
    task automatic t_write_read();
        logic [3:0] r;
        for (int c = 0; c < 16; c++) begin
            sense = {4'h5 ^ 4'(c), 4'(c)};
            u_host_ctrl_model.access({3'h2, c[0]}, 4'(c), r);
            wait_scan(1'b1);
            check(scan, 16'h0001 << c);
            check(antiscan, 1'b0);
            wait_scan(1'b0);
            check(antiscan, 1'b1);
            check(latched, sense);
            u_host_ctrl_model.access(4'h1, 4'h0, r);
            check(r, sense[7:4]);
            u_host_ctrl_model.access(4'h0, 4'h0, r);
            check(r, sense[3:0]);
        end
    endtask : t_write_read

    task automatic t_refused();
        logic [3:0] r;
        logic [3:0] bad [4] = '{4'h2, 4'h7, 4'h8, 4'hC};
        foreach (bad[i]) begin
            seen = 1'b0;
            u_host_ctrl_model.access(bad[i], 4'h3, r);
            repeat (30) @(negedge clk_in);
            check({seen, |scan}, 2'h0);
        end
        check(latched, sense);
    endtask : t_refused

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    initial begin
        #200000;
        err_total++;
        end_sim();
    end

    initial begin
        rst_n_in = 1'b0;
        sense    = 8'h00;
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        t_reset();
        t_write_read();
        t_refused();
        end_sim();
    end
endmodule : tb
